// [verilog/core_exec_pkg.sv]
`default_nettype none
package core_exec_pkg;
  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int PTR_W    = 21;
  localparam int STACK_N  = 8;
  localparam int SP_W     = 4;
  localparam int FSR_W    = 12;
  localparam int ADDR_W   = 9;
  localparam int HOLD_N   = 8;
  localparam int MEM_N    = 256;
  // ****************************************************************
  // opcode patterns
  // ****************************************************************
  localparam logic [14:0] OP_INT_RETURN = 15'h0008;
  localparam logic [7:0]  OP_LIT_RETURN = 8'h0C;
  localparam logic [7:0]  OP_LIT_MINUS  = 8'h08;
  localparam logic [5:0]  OP_FILE_MINUS = 6'h17;
  localparam logic [13:0] OP_TABLE_WR   = 14'h0003;
  localparam logic [7:0]  OP_INDEX_ADD  = 8'hE8;
  localparam logic [7:0]  OP_INDEX_SUB  = 8'hE9;
  localparam logic [7:0]  OP_PUSHL      = 8'hEA;
  localparam logic [7:0]  OP_MOVS       = 8'hEB;
  localparam logic [15:0] OP_CALL_WORK  = 16'h0014;
  localparam logic [3:0]  OP_SECOND  = 4'hF;
  localparam logic [1:0]  FSR_TWO    = 2'h2;
  localparam logic [1:0]  FSR_LINK   = 2'h3;
  localparam logic [7:0]  INDEX_LIM  = 8'h5F;
  localparam logic [7:0]  ACCESS_LIM = 8'h7F;
  // ****************************************************************
  // table write pointer modes
  // ****************************************************************
  localparam logic [1:0] TBL_KEEP = 2'h0;
  localparam logic [1:0] TBL_POSTINC = 2'h1;
  localparam logic [1:0] TBL_POSTDEC = 2'h2;
  localparam logic [1:0] TBL_PREINC = 2'h3;
  // ****************************************************************
  // flag and config bit positions
  // ****************************************************************
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam int CF_EXT = 0;
  localparam int CF_IPEN = 1;
  localparam int CF_HIE = 2;
  localparam int CF_LIE = 3;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [8:0] R_WORK    = 9'h000;
  localparam logic [8:0] R_FLAGS   = 9'h001;
  localparam logic [8:0] R_BANK    = 9'h002;
  localparam logic [8:0] R_SWORK   = 9'h003;
  localparam logic [8:0] R_SFLAGS  = 9'h004;
  localparam logic [8:0] R_SBANK   = 9'h005;
  localparam logic [8:0] R_LATCH   = 9'h006;
  localparam logic [8:0] R_TPTR_L  = 9'h007;
  localparam logic [8:0] R_TPTR_H  = 9'h008;
  localparam logic [8:0] R_TPTR_U  = 9'h009;
  localparam logic [8:0] R_CONFIG  = 9'h00A;
  localparam logic [8:0] R_SLEVEL  = 9'h00B;
  localparam logic [8:0] R_FSR_L   = 9'h00C;
  localparam logic [8:0] R_FSR_H   = 9'h00D;
  localparam logic [8:0] R_FSR_SEL = 9'h00E;
  localparam logic [8:0] R_HOLD    = 9'h018;
  localparam logic [8:0] R_MEM     = 9'h100;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_EXEC   = 3'b001,
    ST_WAIT   = 3'b010,
    ST_SECOND = 3'b100
  } exec_state_t;
endpackage : core_exec_pkg
`default_nettype wire

// [verilog/sub_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sub_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic [7:0] diff;
  logic       carry;
  logic       digit_carry;
  logic       overflow;
  modport alu (input minuend, subtrahend,
               output diff, carry, digit_carry, overflow);
  modport core (output minuend, subtrahend,
                input diff, carry, digit_carry, overflow);
endinterface : sub_if
`default_nettype wire

// [verilog/subtract_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module subtract_unit (
  sub_if.alu s
);
  logic [8:0] full;
  logic [4:0] low;
  // two's complement: minuend + ~subtrahend + 1, carry means no borrow
  assign full = {1'b0, s.minuend} + {1'b0, ~s.subtrahend} + 9'h001;
  assign low  = {1'b0, s.minuend[3:0]} + {1'b0, ~s.subtrahend[3:0]}
                + 5'h01;
  assign s.diff        = full[7:0];
  assign s.carry       = full[8];
  assign s.digit_carry = low[4];
  assign s.overflow    = (s.minuend[7] != s.subtrahend[7])
                         && (full[7] != s.minuend[7]);
endmodule : subtract_unit
`default_nettype wire

// [verilog/core_exec.sv]
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - interrupt return pops stack, sets enable, two cycles
// - option bit restores shadow work, flags, bank
// - 21-bit pointer: keep, post-inc, post-dec, pre-inc
// - pointer spans two megabytes of bytes
// - pointer bit 0 picks low or high byte
// - table write fills holding byte, two cycles
// - 75 standard ops, eight more when extended
// - extension off after reset until config bit set
// - extension makes low file addresses index-relative
// - index-two link add/sub forms also return
// - extended literal ops change or use index pointers
module core_exec
  import core_exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [15:0]       instr,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  output logic                   unsupported,
  output logic [PTR_W-1:0]       pc,
  output logic                   high_priority_int_enable,
  output logic                   low_priority_int_enable,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [7:0]             rdata
);
  // ****************************************************************
  // state
  // ****************************************************************
  exec_state_t state_reg;
  logic [7:0]       work_reg, flags_reg, bank_select_reg;
  logic [7:0]       shadow_work_reg, shadow_flags_reg;
  logic [7:0]       shadow_bank_select_reg, table_latch_reg;
  logic [7:0]       config_reg, fsr_sel_reg, movs_src_reg;
  logic             movs_to_index_reg;
  logic [PTR_W-1:0] table_pointer_reg, pc_reg;
  logic [PTR_W-1:0] stack_reg [STACK_N];
  logic [SP_W-1:0]  sp_reg;
  logic [FSR_W-1:0] fsr_reg [3];
  logic [7:0]       hold_reg [HOLD_N];
  logic [7:0]       mem_reg [MEM_N];
  logic             hie_reg, lie_reg, ready_reg, unsup_reg;
  logic [7:0]       rdata_reg;
  // ****************************************************************
  // decode
  // ****************************************************************
  logic fire, second, ext_en, d_int_ret, d_lit_ret, d_lit_sub, d_file_sub;
  logic d_tbl_wr, d_idx_add, d_idx_sub, d_pushl, d_movs, d_call_work, d_ext;
  logic d_link, do_pop, do_push, bus_mem_wr;
  logic [PTR_W-1:0] stack_top, tp_next, tp_write;
  logic [7:0] k, file_addr, idx2_lo, mv_dst;
  logic [1:0] fsel;
  logic [FSR_W-1:0] k_wide;
  sub_if sif ();

  assign fire = instr_valid && ready_reg && (state_reg == ST_EXEC);
  assign second = instr_valid && (state_reg == ST_SECOND);
  assign ext_en = config_reg[CF_EXT];
  assign k = instr[7:0];
  assign fsel = instr[7:6];
  assign k_wide = {6'h00, instr[5:0]};
  assign idx2_lo = fsr_reg[FSR_TWO][7:0];
  assign d_int_ret = (instr[15:1] == OP_INT_RETURN);
  assign d_lit_ret = (instr[15:8] == OP_LIT_RETURN);
  assign d_lit_sub = (instr[15:8] == OP_LIT_MINUS);
  assign d_file_sub = (instr[15:10] == OP_FILE_MINUS);
  assign d_tbl_wr = (instr[15:2] == OP_TABLE_WR);
  assign d_idx_add = (instr[15:8] == OP_INDEX_ADD);
  assign d_idx_sub = (instr[15:8] == OP_INDEX_SUB);
  assign d_pushl = (instr[15:8] == OP_PUSHL);
  assign d_movs = (instr[15:8] == OP_MOVS);
  assign d_call_work = (instr == OP_CALL_WORK);
  // eight extended codes share these patterns
  assign d_ext = d_idx_add || d_idx_sub || d_pushl || d_movs
                 || d_call_work;
  assign d_link = (d_idx_add || d_idx_sub) && (fsel == FSR_LINK);
  assign do_pop = fire && (d_int_ret || d_lit_ret
                  || (ext_en && d_link));
  assign do_push = fire && ext_en && d_call_work;
  assign stack_top = (sp_reg == '0) ? '0
                     : stack_reg[3'(sp_reg - 4'h1)];
  // below 0x60 in the access bank the operand is index-two relative
  always_comb begin
    if (!instr[8] && ext_en && (instr[7:0] <= INDEX_LIM)) begin
      file_addr = idx2_lo + instr[7:0];
    end else begin
      file_addr = instr[7:0];
    end
  end
  assign mv_dst = movs_to_index_reg ? idx2_lo + {1'b0, instr[6:0]}
                  : instr[7:0];
  assign sif.minuend = d_lit_sub ? k : mem_reg[file_addr];
  assign sif.subtrahend = work_reg;
  subtract_unit u_sub (
    .s (sif)
  );
  // pre-increment moves first and writes at the new address
  always_comb begin
    unique case (instr[1:0])
      TBL_POSTINC: tp_next = table_pointer_reg + 21'h000001;
      TBL_POSTDEC: tp_next = table_pointer_reg - 21'h000001;
      TBL_PREINC:  tp_next = table_pointer_reg + 21'h000001;
      default:     tp_next = table_pointer_reg;
    endcase
  end
  assign tp_write = (instr[1:0] == TBL_PREINC) ? tp_next
                    : table_pointer_reg;
  assign bus_mem_wr = wr && addr[8];
  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_EXEC;
      ready_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_EXEC: begin
          if (fire && (d_int_ret || d_lit_ret || d_tbl_wr
              || (ext_en && (d_link || d_call_work)))) begin
            state_reg <= ST_WAIT;
            ready_reg <= 1'b0;
          end else if (fire && ext_en && d_movs) begin
            state_reg <= ST_SECOND;
          end
        end
        ST_WAIT: begin
          state_reg <= ST_EXEC;
          ready_reg <= 1'b1;
        end
        ST_SECOND: begin
          if (second) begin
            state_reg <= ST_EXEC;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unsup_reg <= 1'b0;
    end else begin
      unsup_reg <= fire && d_ext && !ext_en;
    end
  end
  // ****************************************************************
  // program counter and stack
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= '0;
      sp_reg <= '0;
    end else if (do_pop) begin
      pc_reg <= stack_top;
      if (sp_reg != '0) begin
        sp_reg <= sp_reg - 4'h1;
      end
    end else if (do_push) begin
      pc_reg <= {pc_reg[20:8], work_reg};
      if (sp_reg != STACK_N[SP_W-1:0]) begin
        stack_reg[sp_reg[2:0]] <= pc_reg + 21'h000002;
        sp_reg <= sp_reg + 4'h1;
      end
    end else if (fire || second) begin
      pc_reg <= pc_reg + 21'h000002;
    end
  end
  // ****************************************************************
  // core registers; an instruction wins over a bus write
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      work_reg <= '0;
      flags_reg <= '0;
      bank_select_reg <= '0;
    end else if (fire && d_int_ret && instr[0]) begin
      work_reg <= shadow_work_reg;
      flags_reg <= shadow_flags_reg;
      bank_select_reg <= shadow_bank_select_reg;
    end else if (fire && d_lit_ret) begin
      work_reg <= k;
    end else if (fire && (d_lit_sub || d_file_sub)) begin
      if (d_lit_sub || !instr[9]) begin
        work_reg <= sif.diff;
      end
      flags_reg[FL_C] <= sif.carry;
      flags_reg[FL_DC] <= sif.digit_carry;
      flags_reg[FL_Z] <= (sif.diff == 8'h00);
      flags_reg[FL_OV] <= sif.overflow;
      flags_reg[FL_N] <= sif.diff[7];
    end else if (wr && addr == R_WORK) begin
      work_reg <= wdata;
    end else if (wr && addr == R_FLAGS) begin
      flags_reg <= {3'h0, wdata[4:0]};
    end else if (wr && addr == R_BANK) begin
      bank_select_reg <= wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shadow_work_reg <= '0;
      shadow_flags_reg <= '0;
      shadow_bank_select_reg <= '0;
      table_latch_reg <= '0;
      config_reg <= CONFIG_RST;
      fsr_sel_reg <= '0;
    end else if (wr) begin
      unique case (addr)
        R_SWORK: shadow_work_reg <= wdata;
        R_SFLAGS: shadow_flags_reg <= wdata;
        R_SBANK: shadow_bank_select_reg <= wdata;
        R_LATCH: table_latch_reg <= wdata;
        R_CONFIG: config_reg <= {4'h0, wdata[3:0]};
        R_FSR_SEL: fsr_sel_reg <= {6'h00, wdata[1:0]};
        default: ;
      endcase
    end
  end
  // returning from a low ISR finds the high enable still set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hie_reg <= 1'b0;
      lie_reg <= 1'b0;
    end else if (fire && d_int_ret) begin
      if (config_reg[CF_IPEN] && hie_reg) begin
        lie_reg <= 1'b1;
      end else begin
        hie_reg <= 1'b1;
      end
    end else if (wr && addr == R_CONFIG) begin
      hie_reg <= wdata[CF_HIE];
      lie_reg <= wdata[CF_LIE];
    end
  end
  // ****************************************************************
  // table write: holding bytes only, the array is not programmed
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      table_pointer_reg <= '0;
    end else if (fire && d_tbl_wr) begin
      table_pointer_reg <= tp_next;
    end else if (wr && addr == R_TPTR_L) begin
      table_pointer_reg[7:0] <= wdata;
    end else if (wr && addr == R_TPTR_H) begin
      table_pointer_reg[15:8] <= wdata;
    end else if (wr && addr == R_TPTR_U) begin
      table_pointer_reg[20:16] <= wdata[4:0];
    end
  end
  // bit 0 of the pointer is the byte lane within a word
  always_ff @(posedge clk) begin
    if (fire && d_tbl_wr) begin
      hold_reg[tp_write[2:0]] <= table_latch_reg;
    end else if (wr && addr[8:3] == R_HOLD[8:3]) begin
      hold_reg[addr[2:0]] <= wdata;
    end
  end
  // ****************************************************************
  // index pointers and file memory
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsr_reg <= '{default: '0};
    end else if (fire && ext_en && (d_idx_add || d_idx_sub)) begin
      if (d_idx_add) begin
        fsr_reg[d_link ? FSR_TWO : fsel] <=
          fsr_reg[d_link ? FSR_TWO : fsel] + k_wide;
      end else begin
        fsr_reg[d_link ? FSR_TWO : fsel] <=
          fsr_reg[d_link ? FSR_TWO : fsel] - k_wide;
      end
    end else if (fire && ext_en && d_pushl) begin
      fsr_reg[FSR_TWO] <= fsr_reg[FSR_TWO] - 12'h001;
    end else if (wr && addr == R_FSR_L && fsr_sel_reg[1:0] != FSR_LINK) begin
      fsr_reg[fsr_sel_reg[1:0]][7:0] <= wdata;
    end else if (wr && addr == R_FSR_H && fsr_sel_reg[1:0] != FSR_LINK) begin
      fsr_reg[fsr_sel_reg[1:0]][11:8] <= wdata[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (fire && d_file_sub && instr[9]) begin
      mem_reg[file_addr] <= sif.diff;
    end else if (fire && ext_en && d_pushl) begin
      mem_reg[idx2_lo] <= k;
    end else if (second) begin
      mem_reg[mv_dst] <= movs_src_reg;
    end else if (bus_mem_wr) begin
      mem_reg[addr[7:0]] <= wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      movs_src_reg <= '0;
      movs_to_index_reg <= 1'b0;
    end else if (fire && ext_en && d_movs) begin
      movs_src_reg <= mem_reg[idx2_lo + {1'b0, instr[6:0]}];
      movs_to_index_reg <= instr[7];
    end
  end
  // ****************************************************************
  // register read port
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (rd) begin
      if (addr[8]) begin
        rdata_reg <= mem_reg[addr[7:0]];
      end else if (addr[8:3] == R_HOLD[8:3]) begin
        rdata_reg <= hold_reg[addr[2:0]];
      end else begin
        unique case (addr)
          R_WORK: rdata_reg <= work_reg;
          R_FLAGS: rdata_reg <= flags_reg;
          R_BANK: rdata_reg <= bank_select_reg;
          R_SWORK: rdata_reg <= shadow_work_reg;
          R_SFLAGS: rdata_reg <= shadow_flags_reg;
          R_SBANK: rdata_reg <= shadow_bank_select_reg;
          R_LATCH: rdata_reg <= table_latch_reg;
          R_TPTR_L: rdata_reg <= table_pointer_reg[7:0];
          R_TPTR_H: rdata_reg <= table_pointer_reg[15:8];
          R_TPTR_U: rdata_reg <= {3'h0, table_pointer_reg[20:16]};
          R_CONFIG: rdata_reg <= {config_reg[7:4], lie_reg, hie_reg,
                                  config_reg[1:0]};
          R_SLEVEL: rdata_reg <= {4'h0, sp_reg};
          R_FSR_L: rdata_reg <= fsr_reg[fsr_sel_reg[1:0]][7:0];
          R_FSR_H: rdata_reg <= {4'h0, fsr_reg[fsr_sel_reg[1:0]][11:8]};
          R_FSR_SEL: rdata_reg <= fsr_sel_reg;
          default: rdata_reg <= 8'h00;
        endcase
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign instr_ready = ready_reg;
  assign unsupported = unsup_reg;
  assign pc = pc_reg;
  assign high_priority_int_enable = hie_reg;
  assign low_priority_int_enable = lie_reg;
  assign rdata = rdata_reg;
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_two_cycle;
    !instr_ready ##1 instr_ready;
  endsequence
  property p_int_ret_len;
    fire && d_int_ret |=> s_two_cycle;
  endproperty
  a_int_ret_len: assert property (p_int_ret_len)
    else $error("interrupt return not two cycles");
  property p_int_ret_enable;
    fire && d_int_ret && !config_reg[CF_IPEN]
      |=> high_priority_int_enable && pc == $past(stack_top);
  endproperty
  a_int_ret_enable: assert property (p_int_ret_enable)
    else $error("interrupt return missed enable or pop");
  property p_shadow;
    fire && d_int_ret && instr[0] |=> work_reg == $past(shadow_work_reg)
      && bank_select_reg == $past(shadow_bank_select_reg);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow restore failed");
  property p_no_shadow;
    fire && d_int_ret && !instr[0] |=> $stable(flags_reg);
  endproperty
  a_no_shadow: assert property (p_no_shadow)
    else $error("flags changed without restore");
  property p_tbl_inc;
    fire && d_tbl_wr && instr[1:0] == TBL_POSTINC
      |=> table_pointer_reg == $past(table_pointer_reg) + 21'h000001;
  endproperty
  a_tbl_inc: assert property (p_tbl_inc)
    else $error("post-increment wrong");
  property p_tbl_hold;
    fire && d_tbl_wr && instr[1:0] == TBL_KEEP |=> s_two_cycle and
      hold_reg[$past(table_pointer_reg[2:0])] == $past(table_latch_reg);
  endproperty
  a_tbl_hold: assert property (p_tbl_hold)
    else $error("holding byte not written");
  property p_ext_off;
    fire && d_ext && !ext_en |=> unsupported ##1 !unsupported;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("extended op ran while disabled");
  property p_lit_ret;
    fire && d_lit_ret |=> work_reg == $past(k) && pc == $past(stack_top)
      ##1 instr_ready;
  endproperty
  a_lit_ret: assert property (p_lit_ret)
    else $error("literal return wrong");
  property p_sub_flags;
    fire && d_lit_sub |=> flags_reg[FL_C] == ($past(k) >= $past(work_reg))
      && flags_reg[FL_Z] == ($past(k) == $past(work_reg));
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("subtract flags wrong");
endmodule : core_exec
`default_nettype wire

// [dv/core_return_subtract_tablewrite_exec_test.sv]
`timescale 1ns/1ps
`default_nettype none
module core_return_subtract_tablewrite_exec_test;
  import core_exec_pkg::*;
  logic              clk;
  logic              rstn;
  logic [15:0]       instr;
  logic              instr_valid;
  logic              instr_ready;
  logic              unsupported;
  logic [PTR_W-1:0]  pc;
  logic              hi_en;
  logic              lo_en;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              wr;
  logic              rd;
  logic [7:0]        rdata;
  int                n_errors;
  int                cmp_count;
  int                n_unsup;
  int                cyc = 0;
  logic [7:0]        k, w, v, r, sw, sf, sb;
  logic [5:0]        q;
  logic [1:0]        m;
  logic [12:0]       e;
  logic [PTR_W-1:0]  p, np, ret;

  core_exec dut_u (.clk(clk), .rstn(rstn), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .unsupported(unsupported), .pc(pc),
    .high_priority_int_enable(hi_en), .low_priority_int_enable(lo_en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // refused extended ops are counted here since the pulse lasts one cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (unsupported === 1'b1) n_unsup <= n_unsup + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [PTR_W-1:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // two-cycle ops must drop ready right after the taking edge
  task automatic exec(input logic [15:0] i, input bit two);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 if (two) chk("ready", instr_ready, 1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask : exec

  // result in [7:0], then C, DC, Z, OV, N upward
  function automatic logic [12:0] sub_exp(input logic [7:0] a, b);
    logic [7:0] d;
    d = a - b;
    return {d[7], (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00,
            a[3:0] >= b[3:0], a >= b, d};
  endfunction : sub_exp

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0; instr = 16'h0000; instr_valid = 1'b0; addr = 9'h000;
    wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    n_errors = 0; cmp_count = 0; n_unsup = 0;
    void'($urandom(66034));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("ready", instr_ready, 1'b1);
    rd_reg(R_CONFIG, r);
    chk("config", r, CONFIG_RST);
    p = pc;
    exec({OP_INDEX_ADD, 8'h05}, 0);
    chk("unsup", n_unsup, 1);
    chk("pc", pc, p + 2);
    $display("test 1 done");
    for (int i = 0; i < 25; i++) begin
      k = (i < 3) ? 8'h02 : (i == 3) ? 8'h80 : 8'($urandom);
      w = (i < 3) ? 8'(i + 1) : (i == 3) ? 8'h01 : 8'($urandom);
      wr_reg(R_WORK, w);
      exec({OP_LIT_MINUS, k}, 0);
      e = sub_exp(k, w);
      rd_reg(R_WORK, r);
      chk("lit_minus", r, e[7:0]);
      rd_reg(R_FLAGS, r);
      chk("flags", r[4:0], e[12:8]);
    end
    $display("test 2 done");
    for (int i = 0; i < 8; i++) begin
      k = 8'($urandom);
      v = 8'($urandom);
      w = 8'($urandom);
      wr_reg({1'b1, k}, v);
      wr_reg(R_WORK, w);
      exec({OP_FILE_MINUS, i[0], 1'b1, k}, 0);
      e = sub_exp(v, w);
      rd_reg({1'b1, k}, r);
      chk("file", r, i[0] ? e[7:0] : v);
      rd_reg(R_WORK, r);
      chk("work", r, i[0] ? w : e[7:0]);
      rd_reg(R_FLAGS, r);
      chk("flags", r[4:0], e[12:8]);
    end
    $display("test 3 done");
    // 0,2: restore shadows; 1: no restore; 2: priority mode; 3: literal
    wr_reg(R_CONFIG, 8'h01);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr_reg(R_CONFIG, 8'h07);
      w = 8'($urandom);
      sw = 8'($urandom);
      sf = 8'($urandom);
      sb = 8'($urandom);
      k = 8'($urandom);
      wr_reg(R_SWORK, sw);
      wr_reg(R_SFLAGS, sf);
      wr_reg(R_SBANK, sb);
      wr_reg(R_FLAGS, 8'h00);
      wr_reg(R_BANK, 8'h00);
      wr_reg(R_WORK, w);
      p = pc;
      ret = p + 2;
      exec(OP_CALL_WORK, 1);
      chk("call_work", pc, {p[20:8], w});
      exec(i == 3 ? {OP_LIT_RETURN, k} : {OP_INT_RETURN, ~i[0]}, 1);
      chk("pop", pc, ret);
      rd_reg(R_WORK, r);
      chk("work", r, i == 3 ? k : i[0] ? w : sw);
      rd_reg(R_FLAGS, r);
      chk("flags", r[4:0], i[0] ? 5'h00 : sf[4:0]);
      rd_reg(R_BANK, r);
      chk("bank", r, i[0] ? 8'h00 : sb);
      if (i == 2) chk("low_en", lo_en, 1'b1);
      else if (i < 2) chk("high_en", hi_en, 1'b1);
    end
    chk("unsup", n_unsup, 1);
    $display("test 4 done");
    for (int i = 0; i < 6; i++) begin
      p = (i == 4) ? 21'h1FFFFF : (i == 5) ? 21'h0 : 21'($urandom);
      m = 2'((i < 4) ? i : i - 3);
      np = (m == TBL_KEEP) ? p : (m == TBL_POSTDEC) ? p - 1 : p + 1;
      k = 8'($urandom);
      wr_reg(R_TPTR_L, p[7:0]);
      wr_reg(R_TPTR_H, p[15:8]);
      wr_reg(R_TPTR_U, {3'h0, p[20:16]});
      wr_reg(R_LATCH, k);
      exec({OP_TABLE_WR, m}, 1);
      rd_reg(R_HOLD + {6'h0, (m == TBL_PREINC) ? np[2:0] : p[2:0]}, r);
      chk("hold", r, k);
      rd_reg(R_TPTR_L, r);
      chk("ptr_l", r, np[7:0]);
      rd_reg(R_TPTR_H, r);
      chk("ptr_h", r, np[15:8]);
      rd_reg(R_TPTR_U, r);
      chk("ptr_u", r[4:0], np[20:16]);
    end
    $display("test 5 done");
    // offsets kept clear of the low-byte boundary
    for (int i = 0; i < 2; i++) begin
      v = 8'h40 + 8'($urandom % 128);
      q = 6'($urandom);
      wr_reg(R_FSR_SEL, (i != 0) ? 8'h02 : 8'h00);
      wr_reg(R_FSR_L, v);
      wr_reg(R_FSR_H, 8'h00);
      ret = pc + 2;
      if (i != 0) exec(OP_CALL_WORK, 1);
      exec((i != 0) ? {OP_INDEX_SUB, 2'h3, q} : {OP_INDEX_ADD, 2'h0, q},
           i != 0);
      if (i != 0) chk("ret", pc, ret);
      rd_reg(R_FSR_L, r);
      chk("fsr", r, (i != 0) ? v - {2'h0, q} : v + {2'h0, q});
    end
    $display("test 6 done");
    // index-two relative operand, literal push, indexed move
    v = 8'($urandom);
    w = 8'($urandom);
    k = 8'($urandom);
    q = 6'($urandom);
    wr_reg(R_FSR_L, 8'h20);
    wr_reg({1'b1, 8'h20 + {2'h0, q}}, v);
    wr_reg(R_WORK, w);
    exec({OP_FILE_MINUS, 1'b1, 1'b0, 2'h0, q}, 0);
    e = sub_exp(v, w);
    rd_reg({1'b1, 8'h20 + {2'h0, q}}, r);
    chk("indexed", r, e[7:0]);
    exec({OP_PUSHL, k}, 0);
    rd_reg({1'b1, 8'h20}, r);
    chk("push", r, k);
    rd_reg(R_FSR_L, r);
    chk("push_ptr", r, 8'h1F);
    exec({OP_MOVS, 8'h01}, 0);
    exec({OP_SECOND, 12'h090}, 0);
    rd_reg(9'h190, r);
    chk("move", r, k);
    $display("test 7 done");
    wrap_up();
  end
endmodule : core_return_subtract_tablewrite_exec_test
`default_nettype wire
